// ---- rtl/acac_pkg.sv ----
// constants, layouts and types of the conversion and alert controller
// assumes nothing beyond a systemverilog compiler

package acac_pkg;

  // apb byte addresses, one aligned word each
  localparam logic [7:0] ADDR_RESULT = 8'h00;
  localparam logic [7:0] ADDR_CONFIG = 8'h04;
  localparam logic [7:0] ADDR_LOWER = 8'h08;
  localparam logic [7:0] ADDR_UPPER = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  // reset values: single shot, queue disabled, active low
  localparam logic [15:0] CFG_RESET = 16'h0583;
  localparam logic [11:0] UPPER_RESET = 12'h7ff;
  localparam logic [11:0] LOWER_RESET = 12'h800;
  localparam logic [1:0] QUE_OFF = 2'h3;
  localparam int LIMIT_MSB = 11;

  // status word field positions
  localparam int ST_CONV_BIT = 0;
  localparam int ST_WAKE_BIT = 1;
  localparam int ST_ALERT_BIT = 2;
  localparam int ST_PIN_BIT = 3;
  localparam int ST_ABOVE_BIT = 4;
  localparam int ST_SPAN_LSB = 16;

  // output data rates in samples per second
  localparam int RATE0_SPS = 128;
  localparam int RATE1_SPS = 250;
  localparam int RATE2_SPS = 490;
  localparam int RATE3_SPS = 920;
  localparam int RATE4_SPS = 1600;
  localparam int RATE5_SPS = 2400;
  localparam int RATE6_SPS = 3300;

  // input spans in millivolts
  localparam logic [12:0] SPAN0_MV = 13'd6144;
  localparam logic [12:0] SPAN1_MV = 13'd4096;
  localparam logic [12:0] SPAN2_MV = 13'd2048;
  localparam logic [12:0] SPAN3_MV = 13'd1024;
  localparam logic [12:0] SPAN4_MV = 13'd512;
  localparam logic [12:0] SPAN5_MV = 13'd256;

  // timing in microseconds and oscillator limits
  localparam int WAKE_US = 25;
  localparam int RDY_PULSE_US = 8;
  localparam int US_PER_S = 1000000;
  localparam int OSC_HZ_MIN = 100000;
  localparam int OSC_HZ_MAX = 8000000;

  typedef enum {ST_OFF, ST_WAKE, ST_CONV} acac_state_t;

  // configuration word layout
  typedef struct packed {
    logic trig; // single conversion trigger
    logic [2:0] chan; // input selection, passed to the core
    logic [2:0] fs; // full_scale_select
    logic single; // 1 single shot, 0 continuous
    logic [2:0] rate; // rate_select
    logic window; // 1 window style, 0 traditional
    logic pol; // alert_polarity, 1 active high
    logic latch; // alert_latch_enable
    logic [1:0] que; // alert_queue_count
  } acac_cfg_t;

  // apb request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } acac_apb_req_t;

  // apb answer to the master
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } acac_apb_rsp_t;

endpackage : acac_pkg

// ---- rtl/acac_top.sv ----
// conversion sequencer, threshold comparator and alert pin control
// assumes an apb master on CLK_SYS_I, a free-running oscillator on
// OSC_I, a converter core holding its result until CONV_DONE_O, and an
// i2c front end decoding general call reset and alert response
// Function
// R1: full scale code picks one of six spans
// R2: conversion timing counted from oscillator edges only
// R3: rate code picks one of seven rates
// R4: one conversion lasts one rate period
// R5: traditional: set above upper, release below lower
// R6: window: alert outside either limit
// R7: latched alert held until read or response
// R8: polarity bit sets active level, low default
// R9: alert after one, two or four results
// R10: queue code 11 disables, pin released high
// R11: limit msbs one/zero make ready output
// R12: continuous ready gives 8 us pulse
// R13: single shot ready asserts at conversion end
// R14: cleared alert may set again, conversion untouched
// R15: asserted devices answer the alert command; only a latched comparator alert answers here
// R16: only arbitration winner clears its alert
// R17: window status bit: 1 upper, 0 lower
// R18: reset loads defaults then powers down
// R19: general call reset equals power-up reset
// R20: trigger wakes, converts once, powers down
// R21: trigger write ignored while converting
// R22: mode bit zero selects continuous conversion
// R23: back to back; new settings next conversion
// R24: signed compare once per completed result
module acac_top #(
  parameter int OSC_HZ = 1000000 // oscillator rate; lower it in sims
) (
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic SRST_I,
  // apb slave
  input wire acac_pkg::acac_apb_req_t APB_REQ_I,
  output acac_pkg::acac_apb_rsp_t APB_RSP_O,
  // oscillator pin
  input wire logic OSC_I,
  // converter core
  input wire logic [11:0] CORE_RESULT_I,
  output logic CORE_PWR_O,
  output logic CORE_START_O,
  output logic CONV_DONE_O,
  output logic [2:0] CORE_FS_O,
  output logic [2:0] CORE_CHAN_O,
  output logic [12:0] SPAN_MV_O,
  // i2c front end events
  input wire logic GCALL_RESET_I,
  input wire logic ARA_DONE_I,
  input wire logic ARA_WON_I,
  output logic ARA_PENDING_O,
  output logic ARA_STATUS_O,
  // open-drain alert pin
  output logic ALERT_O,
  output logic ALERT_OE_N_O
);
  import acac_pkg::*;

  // refuse oscillator rates the 16-bit counters cannot serve
  if (OSC_HZ < OSC_HZ_MIN || OSC_HZ > OSC_HZ_MAX) begin : g_chk
    $error("OSC_HZ out of range");
  end

  // wake time rounds up, ready pulse rounds down, both at least one
  localparam int WAKE_TK = (WAKE_US * OSC_HZ + US_PER_S - 1) / US_PER_S;
  localparam int RDY_RAW = (RDY_PULSE_US * OSC_HZ) / US_PER_S;
  localparam int RDY_TK = (RDY_RAW < 1) ? 1 : RDY_RAW;

  // oscillator ticks per conversion for a rate code
  function automatic logic [15:0] conv_ticks(input logic [2:0] sel);
    case (sel) // R3
      3'h0: return 16'(OSC_HZ / RATE0_SPS);
      3'h1: return 16'(OSC_HZ / RATE1_SPS);
      3'h2: return 16'(OSC_HZ / RATE2_SPS);
      3'h3: return 16'(OSC_HZ / RATE3_SPS);
      3'h4: return 16'(OSC_HZ / RATE4_SPS);
      3'h5: return 16'(OSC_HZ / RATE5_SPS);
      default: return 16'(OSC_HZ / RATE6_SPS);
    endcase
  endfunction : conv_ticks

  // span in millivolts for a full scale code; codes 5 to 7 share one
  function automatic logic [12:0] span_mv(input logic [2:0] sel);
    case (sel) // R1
      3'h0: return SPAN0_MV;
      3'h1: return SPAN1_MV;
      3'h2: return SPAN2_MV;
      3'h3: return SPAN3_MV;
      3'h4: return SPAN4_MV;
      default: return SPAN5_MV;
    endcase
  endfunction : span_mv

  // successive results needed for each queue code
  function automatic logic [2:0] que_need(input logic [1:0] q);
    case (q) // R9
      2'h0: return 3'h1;
      2'h1: return 3'h2;
      default: return 3'h4;
    endcase
  endfunction : que_need

  // address decode used by the error answer only; the read mux decodes on its own
  function automatic logic addr_ok(input logic [7:0] a,
                                   input logic wr);
    case (a)
      ADDR_CONFIG, ADDR_LOWER, ADDR_UPPER: return 1'b1;
      ADDR_RESULT, ADDR_STATUS: return ~wr;
      default: return 1'b0;
    endcase
  endfunction : addr_ok

  logic rst; // power-up or general call reset
  logic osc_meta_r; // first synchroniser stage
  logic osc_sync_r; // second synchroniser stage
  logic osc_prev_r; // edge detector history
  logic osc_tick; // one cycle per oscillator rising edge
  acac_state_t state_r; // power and conversion state
  logic [15:0] cnt_r; // oscillator ticks left in this state
  acac_cfg_t cfg_r; // software configuration
  acac_cfg_t act_r; // settings of the running conversion
  acac_cfg_t wcfg; // write data seen as configuration
  logic [11:0] upper_r; // upper_limit
  logic [11:0] lower_r; // lower_limit
  logic [11:0] result_r; // last completed result
  logic shot_req_r; // accepted single conversion request
  logic conv_end; // last tick of a conversion
  logic wake_end; // last tick of power-up
  logic busy; // request pending or core powered
  logic wr_acc; // apb write access phase
  logic rd_acc; // apb read access phase
  logic above; // result above upper_limit
  logic below; // result below lower_limit
  logic beyond; // result counts toward the queue
  logic [2:0] q_cnt_r; // successive results beyond
  logic hit; // queue reached with this result
  logic alert_r; // comparator alert state
  logic above_r; // alert caused by the upper limit
  logic rdy_mode; // pin used as conversion ready
  logic que_off; // comparator disabled
  logic rdy_lvl_r; // single shot ready level
  logic [15:0] rdy_cnt_r; // continuous ready pulse ticks left
  logic clr_evt; // result read or won alert response
  logic pin_active; // pin in its active state
  logic pin_low_r; // pin pulled low
  logic [31:0] prdata_r; // read data captured in setup phase
  logic start_r; // conversion start pulse
  logic done_r; // conversion done pulse
  logic [12:0] span_r; // span of the running conversion

  // general call reset acts exactly like the external reset
  assign rst = SRST_I | GCALL_RESET_I; // R18 R19

  // oscillator pin: two flops, then edge detect on the second
  always_ff @(posedge CLK_SYS_I) begin
    osc_meta_r <= OSC_I;
    osc_sync_r <= osc_meta_r;
    osc_prev_r <= osc_sync_r;
  end
  assign osc_tick = osc_sync_r & ~osc_prev_r; // R2

  // apb phases; the slave always answers without wait states
  assign wr_acc = APB_REQ_I.psel & APB_REQ_I.penable & APB_REQ_I.pwrite;
  assign rd_acc = APB_REQ_I.psel & APB_REQ_I.penable &
                  ~APB_REQ_I.pwrite;
  assign wcfg = acac_cfg_t'(APB_REQ_I.pwdata[15:0]);

  // end of the power-up wait and of a conversion
  assign wake_end = (state_r == ST_WAKE) & osc_tick & (cnt_r == 16'h1);
  assign conv_end = (state_r == ST_CONV) & osc_tick & (cnt_r == 16'h1);
  assign busy = shot_req_r | (state_r != ST_OFF);

  // configuration register; the trigger bit is never stored here
  always_ff @(posedge CLK_SYS_I) begin
    if (rst) begin
      cfg_r <= acac_cfg_t'(CFG_RESET); // R18
    end else if (wr_acc && APB_REQ_I.paddr == ADDR_CONFIG) begin
      cfg_r <= wcfg; // R22
      cfg_r.trig <= 1'b0;
    end
  end

  // limit registers
  always_ff @(posedge CLK_SYS_I) begin
    if (rst) begin
      upper_r <= UPPER_RESET;
      lower_r <= LOWER_RESET;
    end else if (wr_acc && APB_REQ_I.paddr == ADDR_UPPER) begin
      upper_r <= APB_REQ_I.pwdata[11:0];
    end else if (wr_acc && APB_REQ_I.paddr == ADDR_LOWER) begin
      lower_r <= APB_REQ_I.pwdata[11:0];
    end
  end

  // single conversion request: only taken while fully idle
  always_ff @(posedge CLK_SYS_I) begin
    if (rst) begin
      shot_req_r <= 1'b0;
    end else if (state_r == ST_OFF && shot_req_r) begin
      shot_req_r <= 1'b0; // R20
    end else if (wr_acc && APB_REQ_I.paddr == ADDR_CONFIG &&
                 wcfg.trig && wcfg.single && state_r == ST_OFF) begin
      shot_req_r <= 1'b1; // R21
    end
  end

  // power and conversion sequencing
  always_ff @(posedge CLK_SYS_I) begin
    if (rst) begin
      state_r <= ST_OFF; // R18
    end else begin
      unique case (state_r)
        ST_OFF: begin
          // continuous mode wakes on its own, single shot on request
          if (shot_req_r || !cfg_r.single) begin
            state_r <= ST_WAKE; // R20 R22
          end
        end
        ST_WAKE: begin
          if (wake_end) begin
            state_r <= ST_CONV;
          end
        end
        ST_CONV: begin
          // a mode change made mid-conversion acts at its end
          if (conv_end && cfg_r.single) begin
            state_r <= ST_OFF; // R20
          end
        end
      endcase
    end
  end

  // tick counter; settings are frozen at each conversion start
  always_ff @(posedge CLK_SYS_I) begin
    if (rst) begin
      cnt_r <= 16'h0;
      act_r <= acac_cfg_t'(CFG_RESET);
    end else if (state_r == ST_OFF) begin
      cnt_r <= 16'(WAKE_TK);
    end else if (wake_end || (conv_end && !cfg_r.single)) begin
      cnt_r <= conv_ticks(cfg_r.rate); // R4 R23
      act_r <= cfg_r; // R23
    end else if (osc_tick) begin
      cnt_r <= cnt_r - 16'h1; // R2
    end
  end

  // core handshake pulses, result capture and span
  always_ff @(posedge CLK_SYS_I) begin
    if (rst) begin
      start_r <= 1'b0;
      done_r <= 1'b0;
      result_r <= 12'h0;
      span_r <= span_mv(CFG_RESET[11:9]);
    end else begin
      start_r <= wake_end | (conv_end & ~cfg_r.single); // R23
      done_r <= conv_end;
      if (conv_end) begin
        result_r <= CORE_RESULT_I; // R23
      end
      if (wake_end || (conv_end && !cfg_r.single)) begin
        span_r <= span_mv(cfg_r.fs); // R1
      end
    end
  end

  // comparator inputs, evaluated only at conv_end
  assign above = $signed(CORE_RESULT_I) > $signed(upper_r); // R24
  assign below = $signed(CORE_RESULT_I) < $signed(lower_r); // R24
  assign beyond = cfg_r.window ? (above | below) : above; // R5 R6
  assign hit = beyond & ((q_cnt_r + 3'h1) >= que_need(cfg_r.que)); // R9
  assign que_off = cfg_r.que == QUE_OFF; // R10
  assign rdy_mode = upper_r[LIMIT_MSB] & ~lower_r[LIMIT_MSB] &
                    ~que_off; // R11
  // a result read or a won response clears a latched alert
  assign clr_evt = (rd_acc & (APB_REQ_I.paddr == ADDR_RESULT)) |
                   (ARA_DONE_I & ARA_WON_I); // R7 R16

  // queue of successive out-of-limit results, saturating at four
  always_ff @(posedge CLK_SYS_I) begin
    if (rst || que_off || rdy_mode) begin
      q_cnt_r <= 3'h0;
    end else if (conv_end) begin
      if (!beyond) begin
        q_cnt_r <= 3'h0; // R9
      end else if (q_cnt_r != 3'h4) begin
        q_cnt_r <= q_cnt_r + 3'h1;
      end
    end
  end

  // alert state; a new hit wins over a clear in the same cycle
  always_ff @(posedge CLK_SYS_I) begin
    if (rst || que_off || rdy_mode) begin
      alert_r <= 1'b0; // R10 R11
      above_r <= 1'b0;
    end else if (conv_end && hit) begin
      alert_r <= 1'b1; // R5 R6 R14
      above_r <= above; // R17
    end else if (cfg_r.latch) begin
      if (clr_evt) begin
        alert_r <= 1'b0; // R7 R14
      end
    end else if (conv_end && cfg_r.window && !beyond) begin
      alert_r <= 1'b0; // R6
    end else if (conv_end && !cfg_r.window && below) begin
      alert_r <= 1'b0; // R5
    end
  end

  // conversion ready: pulse in continuous, level in single shot
  always_ff @(posedge CLK_SYS_I) begin
    if (rst) begin
      rdy_lvl_r <= 1'b0;
      rdy_cnt_r <= 16'h0;
    end else begin
      if (conv_end && cfg_r.single) begin
        rdy_lvl_r <= 1'b1; // R13
      end else if (state_r == ST_WAKE) begin
        rdy_lvl_r <= 1'b0;
      end
      if (conv_end && !cfg_r.single) begin
        rdy_cnt_r <= 16'(RDY_TK); // R12
      end else if (osc_tick && rdy_cnt_r != 16'h0) begin
        rdy_cnt_r <= rdy_cnt_r - 16'h1;
      end
    end
  end

  // pin level: polarity applies to both uses, disable releases it
  assign pin_active = rdy_mode ?
                      (rdy_lvl_r | (rdy_cnt_r != 16'h0)) : alert_r; // R11
  always_ff @(posedge CLK_SYS_I) begin
    if (rst || que_off) begin
      pin_low_r <= 1'b0; // R10
    end else begin
      pin_low_r <= pin_active ^ cfg_r.pol; // R8
    end
  end

  // read data is captured in the setup phase so it leaves a flop
  always_ff @(posedge CLK_SYS_I) begin
    if (rst) begin
      prdata_r <= 32'h0;
    end else if (APB_REQ_I.psel && !APB_REQ_I.penable) begin
      prdata_r <= 32'h0;
      case (APB_REQ_I.paddr)
        ADDR_RESULT: prdata_r[11:0] <= result_r;
        ADDR_CONFIG: begin
          prdata_r[15:0] <= cfg_r;
          prdata_r[15] <= ~busy;
        end
        ADDR_LOWER: prdata_r[11:0] <= lower_r;
        ADDR_UPPER: prdata_r[11:0] <= upper_r;
        ADDR_STATUS: begin
          prdata_r[ST_CONV_BIT] <= state_r == ST_CONV;
          prdata_r[ST_WAKE_BIT] <= state_r == ST_WAKE;
          prdata_r[ST_ALERT_BIT] <= alert_r;
          prdata_r[ST_PIN_BIT] <= pin_active & ~que_off;
          prdata_r[ST_ABOVE_BIT] <= above_r;
          prdata_r[ST_SPAN_LSB +: 13] <= span_r;
        end
        default: prdata_r <= 32'h0;
      endcase
    end
  end

  // apb answer: zero wait states, error on unmapped or read-only
  always_comb begin
    APB_RSP_O.prdata = prdata_r;
    APB_RSP_O.pready = 1'b1;
    APB_RSP_O.pslverr = APB_REQ_I.psel & APB_REQ_I.penable &
                        ~addr_ok(APB_REQ_I.paddr, APB_REQ_I.pwrite);
  end

  // alert response: answer only for a latched comparator alert
  assign ARA_PENDING_O = alert_r & cfg_r.latch; // R15
  assign ARA_STATUS_O = cfg_r.window ? above_r : 1'b1; // R17

  // core side outputs
  assign CORE_PWR_O = state_r != ST_OFF; // R18
  assign CORE_START_O = start_r;
  assign CONV_DONE_O = done_r;
  assign CORE_FS_O = act_r.fs;
  assign CORE_CHAN_O = act_r.chan;
  assign SPAN_MV_O = span_r;

  // open drain: the output is always low, the enable decides
  assign ALERT_O = 1'b0;
  assign ALERT_OE_N_O = ~pin_low_r;

endmodule : acac_top

// ---- tb/acac_top_asserts.sv ----
// checker: port-level behaviour of acac_top
// assumes one clock domain; bound into acac_top below
module acac_top_asserts
  import acac_pkg::*;
#(
  parameter int OSC_HZ = 1000000 // oscillator rate
) (
  // clock and resets
  input wire logic CLK_SYS_I,
  input wire logic SRST_I,
  input wire logic GCALL_RESET_I,
  // apb and alert response events
  input wire acac_pkg::acac_apb_req_t APB_REQ_I,
  input wire logic ARA_DONE_I,
  input wire logic ARA_WON_I,
  // design outputs
  input wire logic CORE_PWR_O,
  input wire logic CORE_START_O,
  input wire logic CONV_DONE_O,
  input wire logic [2:0] CORE_FS_O,
  input wire logic [12:0] SPAN_MV_O,
  input wire logic ARA_PENDING_O,
  input wire logic ALERT_OE_N_O
);
  // an oscillator tick needs at least two clocks to be seen
  localparam int MIN_CYC = 2 * (OSC_HZ / RATE6_SPS);
  logic [15:0] gap_r; // cycles since the last result
  logic acc; // apb access phase
  logic won; // won alert response
  logic rd0; // access reading the result
  assign acc = APB_REQ_I.psel && APB_REQ_I.penable;
  assign won = ARA_DONE_I && ARA_WON_I;
  assign rd0 = acc && !APB_REQ_I.pwrite && APB_REQ_I.paddr == ADDR_RESULT;
  // saturating count between results
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I || GCALL_RESET_I || CONV_DONE_O) begin
      gap_r <= 16'h0;
    end else if (gap_r != 16'hffff) begin
      gap_r <= gap_r + 16'h1;
    end
  end
  // span for each full-scale code
  localparam logic [12:0] SPANS [8] = '{SPAN0_MV, SPAN1_MV, SPAN2_MV,
    SPAN3_MV, SPAN4_MV, SPAN5_MV, SPAN5_MV, SPAN5_MV};
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (SRST_I || GCALL_RESET_I);
  // no restart right after a start
  sequence s_quiet;
    !CORE_START_O [*8];
  endsequence
  // alert gone, unless a new hit landed at the same edge
  sequence s_cleared;
    !ARA_PENDING_O || CONV_DONE_O;
  endsequence
  AST_PIN_RESET: assert property (
    $past(SRST_I || GCALL_RESET_I) |-> ALERT_OE_N_O)
    else $error("alert pin not released after reset");
  AST_START_PWR: assert property (CORE_START_O |-> CORE_PWR_O)
    else $error("conversion start while powered down");
  AST_START_GAP: assert property (CORE_START_O |=> s_quiet)
    else $error("second start inside a conversion");
  AST_DONE_PULSE: assert property (CONV_DONE_O |=> !CONV_DONE_O)
    else $error("done pulse longer than one cycle");
  AST_CONV_LEN: assert property (CONV_DONE_O |-> gap_r >= MIN_CYC)
    else $error("conversion shorter than the fastest rate");
  AST_SPAN_MAP: assert property (
    CONV_DONE_O |-> SPAN_MV_O == SPANS[CORE_FS_O])
    else $error("span does not match full-scale code");
  AST_FROZEN: assert property (
    CORE_PWR_O && !CORE_START_O && !$past(CORE_START_O)
    |-> $stable(CORE_FS_O) && $stable(SPAN_MV_O))
    else $error("settings changed inside a conversion");
  AST_LATCH_HOLD: assert property (
    ARA_PENDING_O && !acc && !won |=> ARA_PENDING_O)
    else $error("latched alert dropped without a clear");
  AST_ARA_CLEAR: assert property (ARA_PENDING_O && won |=> s_cleared)
    else $error("won alert response did not clear");
  AST_READ_CLEAR: assert property (ARA_PENDING_O && rd0 |=> s_cleared)
    else $error("result read did not clear the alert");
endmodule : acac_top_asserts

bind acac_top acac_top_asserts #(.OSC_HZ(OSC_HZ)) acac_top_asserts_i (
  .CLK_SYS_I(CLK_SYS_I), .SRST_I(SRST_I), .GCALL_RESET_I(GCALL_RESET_I),
  .APB_REQ_I(APB_REQ_I), .ARA_DONE_I(ARA_DONE_I), .ARA_WON_I(ARA_WON_I),
  .CORE_PWR_O(CORE_PWR_O), .CORE_START_O(CORE_START_O),
  .CONV_DONE_O(CONV_DONE_O), .CORE_FS_O(CORE_FS_O), .SPAN_MV_O(SPAN_MV_O),
  .ARA_PENDING_O(ARA_PENDING_O), .ALERT_OE_N_O(ALERT_OE_N_O));

// ---- tb/acac_far.sv ----
// far side: oscillator, converter core and i2c front end
// assumes the bench sets the next result and calls the tasks
module acac_far (
  // clock
  input wire logic clk_i,
  // core side
  input wire logic pwr_i,
  input wire logic [11:0] val_i,
  output logic osc_o,
  output logic [11:0] result_o,
  // front end events
  output logic gcall_o,
  output logic ara_done_o,
  output logic ara_won_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // free-running oscillator, phase unrelated to the clock
  initial begin
    osc_o = 1'b0;
    gcall_o = 1'b0;
    ara_done_o = 1'b0;
    ara_won_o = 1'b0;
    #37;
    forever #100 osc_o = ~osc_o;
  end
  // an unpowered core shows no valid data
  assign result_o = pwr_i ? val_i : ~val_i;
  // alert response with its arbitration outcome
  task automatic ara(input logic w);
    @(posedge clk_i);
    ara_done_o <= 1'b1;
    ara_won_o <= w;
    @(posedge clk_i);
    ara_done_o <= 1'b0;
    ara_won_o <= ~w;
  endtask : ara
  // general call reset command
  task automatic gcall();
    @(posedge clk_i);
    gcall_o <= 1'b1;
    @(posedge clk_i);
    gcall_o <= 1'b0;
  endtask : gcall
endmodule : acac_far

// ---- tb/acac_top_tb.sv ----
// bench: apb, core result and alert response around acac_top
// assumes the checker bind and the acac_far model
module acac_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import acac_pkg::*;
  localparam int OSC = 100000; // slow oscillator keeps runs short
  logic clk, rst, osc, gc, ara_d, ara_w, pwr, start, done, pend, stat;
  logic oe_n, e;
  logic [11:0] val, res;
  logic [12:0] span;
  logic [31:0] q;
  logic [15:0] cfg;
  acac_apb_req_t req;
  acac_apb_rsp_t rsp;
  time t_st, t_dn;
  int n_fail, compares, len, n;
  int rates[8] = '{RATE0_SPS, RATE1_SPS, RATE2_SPS, RATE3_SPS, RATE4_SPS,
    RATE5_SPS, RATE6_SPS, RATE6_SPS};
  logic [12:0] spans[8] = '{SPAN0_MV, SPAN1_MV, SPAN2_MV, SPAN3_MV,
    SPAN4_MV, SPAN5_MV, SPAN5_MV, SPAN5_MV};
  acac_top #(.OSC_HZ(OSC)) acac_top_i (.CLK_SYS_I(clk), .SRST_I(rst),
    .APB_REQ_I(req), .APB_RSP_O(rsp), .OSC_I(osc), .CORE_RESULT_I(res),
    .CORE_PWR_O(pwr), .CORE_START_O(start), .CONV_DONE_O(done),
    .CORE_FS_O(), .CORE_CHAN_O(), .SPAN_MV_O(span), .GCALL_RESET_I(gc),
    .ARA_DONE_I(ara_d), .ARA_WON_I(ara_w), .ARA_PENDING_O(pend),
    .ARA_STATUS_O(stat), .ALERT_O(), .ALERT_OE_N_O(oe_n));
  acac_far acac_far_i (.clk_i(clk), .pwr_i(pwr), .val_i(val), .osc_o(osc),
    .result_o(res), .gcall_o(gc), .ara_done_o(ara_d), .ara_won_o(ara_w));
  // clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // moments of the last start and result, sampled off the edge
  always @(negedge clk) begin
    if (start) t_st = $time;
    if (done) t_dn = $time;
  end
  task automatic chk(input string nm, input logic [31:0] x, g);
    compares++;
    if (g !== x) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  task automatic chk_rng(input string nm, input int lo, hi, g);
    compares++;
    if (g < lo || g > hi) begin
      n_fail++;
      $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : chk_rng
  // one apb transfer; waits for pready, bounded
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] rq, output logic er);
    int k;
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (rsp.pready !== 1'b1 && k < 50);
    rq = rsp.prdata;
    er = rsp.pslverr;
    if (k >= 50) chk("pready", 1, 0);
    req <= '0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    apb(1'b0, a, 32'h0, q, e);
  endtask : rdr
  // waits for a start, then counts cycles to the result
  task automatic conv();
    n = 0;
    while (start !== 1'b1 && n < 9000) begin @(negedge clk); n++; end
    len = 0;
    while (done !== 1'b1 && len < 9000) begin @(negedge clk); len++; end
    if (n >= 9000 || len >= 9000) chk("conversion", 0, 1);
  endtask : conv
  // single conversion of value v with the current settings
  task automatic shot(input logic [11:0] v);
    @(posedge clk);
    val <= v;
    wr(ADDR_CONFIG, {16'h0, 1'b1, cfg[14:0]});
    conv();
    repeat (4) @(negedge clk);
  endtask : shot
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test
  // watchdog
  initial begin
    #1500000;
    n_fail++;
    end_of_test();
  end
  initial begin
    rst = 1'b1;
    req = '0;
    val = 12'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rdr(ADDR_CONFIG);
    chk("config", {16'h0, 1'b1, CFG_RESET[14:0]}, q);
    rdr(ADDR_UPPER);
    chk("upper", {20'h0, UPPER_RESET}, q);
    chk("pin", 1, oe_n);
    chk("pwr", 0, pwr);
    apb(1'b0, 8'h14, 32'h0, q, e);
    chk("slverr", 1, e);
    apb(1'b1, ADDR_RESULT, 32'h5, q, e);
    chk("slverr", 1, e);
    $display("test reset done");
    for (int r = 0; r < 8; r++) begin
      cfg = {4'h0, r[2:0], 1'b1, r[2:0], 3'h0, QUE_OFF};
      shot(12'h0);
      chk("span", spans[r], span);
      n = (OSC / rates[r]) * 8;
      chk_rng("conv_len", n - 4, n + 5, len);
    end
    $display("test rates done");
    wr(ADDR_UPPER, 32'h100);
    wr(ADDR_LOWER, 32'h080);
    // config words: full scale code 2 except 00c0 with code 0, rate code 6
    cfg = 16'h05c4;
    @(posedge clk);
    val <= 12'h200;
    wr(ADDR_CONFIG, {16'h0, 1'b1, cfg[14:0]});
    rdr(ADDR_CONFIG);
    chk("trig_busy", 0, q[15]);
    wr(ADDR_CONFIG, {16'h0, 1'b1, cfg[14:0]});
    conv();
    repeat (300) @(negedge clk);
    chk("pend", 1, pend);
    chk("stat", 1, stat);
    chk("pin", 0, oe_n);
    chk("pwr", 0, pwr);
    chk("one_start", 1, t_st < t_dn);
    acac_far_i.ara(1'b0);
    repeat (3) @(negedge clk);
    chk("pend", 1, pend);
    acac_far_i.ara(1'b1);
    repeat (3) @(negedge clk);
    chk("pend", 0, pend);
    shot(12'h0c0);
    chk("pend", 0, pend);
    shot(12'h200);
    chk("pend", 1, pend);
    rdr(ADDR_RESULT);
    chk("result", 32'h200, q);
    repeat (3) @(negedge clk);
    chk("pend", 0, pend);
    $display("test latch done");
    cfg = 16'h05c8;
    shot(12'h200);
    chk("pin", 1, oe_n);
    shot(12'h0c0);
    chk("pin", 1, oe_n);
    shot(12'h000);
    chk("pin", 0, oe_n);
    cfg = 16'h05d4;
    shot(12'hf00);
    chk("stat", 0, stat);
    acac_far_i.ara(1'b1);
    shot(12'h200);
    chk("stat", 1, stat);
    rdr(ADDR_RESULT);
    $display("test polarity and window done");
    for (int c = 0; c < 3; c++) begin
      cfg = 16'h05d0 | 16'(c[1:0]);
      shot(12'h0c0);
      for (int k = 1; k <= (1 << c); k++) begin
        shot(12'h200);
        chk("queue", k < (1 << c), oe_n);
      end
    end
    cfg = 16'h05d3;
    shot(12'h200);
    chk("que_off", 1, oe_n);
    $display("test queue done");
    wr(ADDR_UPPER, 32'h800);
    wr(ADDR_LOWER, 32'h000);
    cfg = 16'h05c0;
    shot(12'h000);
    chk("ready_single", 0, oe_n);
    cfg = 16'h04c0;
    wr(ADDR_CONFIG, {16'h0, cfg});
    conv();
    n = 0;
    while (oe_n !== 1'b0 && n < 9) begin @(negedge clk); n++; end
    len = 0;
    while (oe_n === 1'b0 && len < 40) begin @(negedge clk); len++; end
    chk_rng("rdy_pulse", 5, 12, len);
    chk("restart", 1, t_st + 30 > t_dn && t_st < t_dn + 100);
    cfg = 16'h00c0;
    wr(ADDR_CONFIG, {16'h0, cfg});
    chk("span_old", SPAN2_MV, span);
    conv();
    chk("span_new", SPAN0_MV, span);
    cfg = 16'h05c0;
    wr(ADDR_CONFIG, {16'h0, cfg});
    repeat (400) @(negedge clk);
    chk("pwr", 0, pwr);
    $display("test ready done");
    wr(ADDR_LOWER, 32'h123);
    acac_far_i.gcall();
    rdr(ADDR_LOWER);
    chk("lower", {20'h0, LOWER_RESET}, q);
    rdr(ADDR_CONFIG);
    chk("config", {16'h0, 1'b1, CFG_RESET[14:0]}, q);
    chk("pin", 1, oe_n);
    $display("test general call done");
    end_of_test();
  end
endmodule : acac_top_tb
